// *** core/emu_map_pkg.sv ***
package emu_map_pkg;

    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int REGION_W = 10;
    localparam int REGION_SHIFT = 10;
    localparam int REGIONS = 1024;
    localparam int MEM_AW = 11;
    localparam int MEM_DEPTH = 2048;

    // Peripheral register area and the interrupt acknowledge location.
    localparam logic [19:0] PERIPH_LAST = 20'h003ff;
    localparam logic [19:0] INT_VEC_ADDR = 20'h00000;
    localparam logic [REGION_W-1:0] PERIPH_REGION = 10'h000;

    // Reserved vector words and the reset stack bytes, each four bytes long.
    localparam logic [19:0] DEBUG_VEC_BASE = 20'hffff4;
    localparam logic [19:0] STEP_VEC_BASE = 20'hfffec;
    localparam logic [19:0] BRK_VEC_BASE = 20'hfffe4;
    localparam logic [19:0] RST_STACK_BASE = 20'h0fffc;

    localparam logic [7:0] BREAK_OPCODE = 8'h00;
    localparam logic [15:0] INDEF_DATA = 16'hffff;

    localparam logic [1:0] STROBE_CYCLES = 2'h2;

    // Hold entry delay, given in half cycles and rounded up to whole cycles.
    localparam int HOLD_DELAY_HALF = 5;
    localparam int HOLD_CYCLES_INT = (HOLD_DELAY_HALF + 1) / 2;
    localparam logic [1:0] HOLD_CYCLES = HOLD_CYCLES_INT[1:0];

    typedef enum logic [1:0] {AREA_PERIPH, AREA_INT, AREA_EXT} area_t;
    typedef enum logic [1:0] {ST_IDLE, ST_LATCH, ST_STROBE, ST_DONE} bus_state_t;

endpackage : emu_map_pkg

// *** core/emulation_map_bus_monitor.sv ***
// Behaviour
// - Regions mapped internal are served from the emulation memory, not the target.
// - Regions mapped to the target side bypass emulation memory and run an external bus cycle, or a peripheral area cycle for 000h-3FFh.
// - After reset every region except the peripheral register area 000h-3FFh is mapped internal.
// - Any read of 00000h pulses the clear of the highest-priority pending request bit.
// - A read of 00000h that is not an interrupt acknowledge lights the alarm.
// - The alarm stays lit until the main unit reset switch clears it.
// - Reads of the debug, single-step and break vector words return indefinite data when their region is mapped internal.
// - A software break returns the break opcode 00h on a fetch of its location.
// - Software breaks have no effect in regions mapped to the target side.
// - During reset handling the stack bytes 0FFFCh-0FFFFh are always kept in emulation memory.
// - Peripheral area cycles drive data only on writes, strobe RD or WR low, keep CS high and pulse ALE.
// - Internal cycles drive address and upper byte enable, float data, keep RD, WR, CS high and pulse ALE.
// - External cycles drive address, enable, CS and ALE, strobe RD or WR low and sample data on reads.
// - A low hold request puts the ports in hold 3 cycles (2.5 rounded up) later than the real part.
module emulation_map_bus_monitor (
    input wire logic clk_sys,
    input wire logic resetn,
    // Evaluation controller request
    input wire logic cpuReq,
    input wire logic cpuWrite,
    input wire logic cpuFetch,
    input wire logic cpuIntAck,
    input wire logic [1:0] cpuByteEn,
    input wire logic [19:0] cpuAddr,
    input wire logic [15:0] cpuWdata,
    input wire logic resetHandling,
    // Evaluation controller answer
    output logic cpuDone,
    output logic [15:0] cpuRdata,
    output logic intRequestClear,
    // Host debugger settings
    input wire logic mapWe,
    input wire logic [9:0] mapRegion,
    input wire logic mapInternal,
    input wire logic breakWe,
    input wire logic [10:0] breakIndex,
    input wire logic breakSet,
    // Target bus pins
    output logic [19:0] extAddr,
    output logic upper_byte_enable_n,
    output logic extAle,
    output logic extRdN,
    output logic extWrN,
    output logic extCsN,
    output logic [15:0] extDataOut,
    output logic extDataOe,
    input wire logic [15:0] extDataIn,
    input wire logic holdReqN,
    output logic portsHold,
    // Front panel
    output logic alarmLed
);

    logic [emu_map_pkg::REGIONS-1:0] mapReg;
    logic [15:0] mem [emu_map_pkg::MEM_DEPTH];
    logic breakFlag [emu_map_pkg::MEM_DEPTH];
    logic [15:0] dataSync1Reg, dataSync2Reg, memRd;
    logic holdSync1Reg, holdSync2Reg, portsHoldNext;
    logic [1:0] holdCntReg, holdCntNext;
    emu_map_pkg::bus_state_t stateReg, stateNext;
    emu_map_pkg::area_t areaReg, areaNext;
    logic [1:0] cntReg, cntNext, beReg, beNext;
    logic [19:0] addrReg, addrNext, extAddrNext;
    logic [15:0] wdataReg, wdataNext;
    logic writeReg, writeNext, fetchReg, fetchNext, ackReg, ackNext;
    logic doneNext, ubeNext, aleNext, rdNext, wrNext, csNext, oeNext, clrNext, alarmNext;
    logic [15:0] rdataNext, doutNext;
    logic [9:0] reqRegion;
    logic inStack, mappedInt, isPeriph, vecRead, breakRd;
    logic [10:0] memIdx;
    assign memIdx = addrReg[emu_map_pkg::MEM_AW:1];
    // Reads are combinational so that the latch cycle sees the word of the address just latched.
    assign memRd = mem[memIdx];
    assign breakRd = breakFlag[memIdx];
    assign reqRegion = cpuAddr[emu_map_pkg::REGION_SHIFT +: emu_map_pkg::REGION_W];
    assign inStack = (cpuAddr[19:2] == emu_map_pkg::RST_STACK_BASE[19:2]);
    assign isPeriph = (cpuAddr <= emu_map_pkg::PERIPH_LAST);
    assign vecRead = (addrReg[19:2] == emu_map_pkg::DEBUG_VEC_BASE[19:2])
        || (addrReg[19:2] == emu_map_pkg::STEP_VEC_BASE[19:2])
        || (addrReg[19:2] == emu_map_pkg::BRK_VEC_BASE[19:2]);
    assign mappedInt = mapReg[reqRegion] || (resetHandling && inStack);
    genvar g;
    generate
        for (g = 0; g < emu_map_pkg::REGIONS; g++) begin : g_map
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    mapReg[g] <= (g != emu_map_pkg::PERIPH_REGION);
                end else if (mapWe && mapRegion == g) begin
                    mapReg[g] <= mapInternal;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (stateReg == emu_map_pkg::ST_LATCH && areaReg == emu_map_pkg::AREA_INT && writeReg) begin
            if (beReg[0]) begin
                mem[memIdx][7:0] <= wdataReg[7:0];
            end
            if (beReg[1]) begin
                mem[memIdx][15:8] <= wdataReg[15:8];
            end
        end
        if (breakWe) begin
            breakFlag[breakIndex] <= breakSet;
        end
    end

    always_comb begin
        holdCntNext = '0;
        portsHoldNext = 1'b0;
        if (!holdSync2Reg) begin
            if (holdCntReg == emu_map_pkg::HOLD_CYCLES) begin
                holdCntNext = holdCntReg;
                portsHoldNext = 1'b1;
            end else begin
                holdCntNext = holdCntReg + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dataSync1Reg <= '0;
            dataSync2Reg <= '0;
            holdSync1Reg <= 1'b1;
            holdSync2Reg <= 1'b1;
            holdCntReg <= '0;
            portsHold <= 1'b0;
        end else begin
            dataSync1Reg <= extDataIn;
            dataSync2Reg <= dataSync1Reg;
            holdSync1Reg <= holdReqN;
            holdSync2Reg <= holdSync1Reg;
            holdCntReg <= holdCntNext;
            portsHold <= portsHoldNext;
        end
    end

    always_comb begin
        stateNext = stateReg;
        areaNext = areaReg;
        cntNext = cntReg;
        addrNext = addrReg;
        wdataNext = wdataReg;
        beNext = beReg;
        writeNext = writeReg;
        fetchNext = fetchReg;
        ackNext = ackReg;
        doneNext = 1'b0;
        clrNext = 1'b0;
        rdataNext = cpuRdata;
        alarmNext = alarmLed;
        extAddrNext = extAddr;
        ubeNext = upper_byte_enable_n;
        aleNext = 1'b0;
        rdNext = 1'b1;
        wrNext = 1'b1;
        csNext = 1'b1;
        oeNext = 1'b0;
        doutNext = extDataOut;
        unique case (stateReg)
            emu_map_pkg::ST_IDLE: begin
                if (cpuReq && !portsHold) begin
                    addrNext = cpuAddr;
                    wdataNext = cpuWdata;
                    beNext = cpuByteEn;
                    writeNext = cpuWrite;
                    fetchNext = cpuFetch;
                    ackNext = cpuIntAck;
                    if (mappedInt) begin
                        areaNext = emu_map_pkg::AREA_INT;
                    end else if (isPeriph) begin
                        areaNext = emu_map_pkg::AREA_PERIPH;
                    end else begin
                        areaNext = emu_map_pkg::AREA_EXT;
                    end
                    extAddrNext = cpuAddr;
                    ubeNext = !cpuByteEn[1];
                    aleNext = 1'b1;
                    stateNext = emu_map_pkg::ST_LATCH;
                end
            end
            emu_map_pkg::ST_LATCH: begin
                if (areaReg == emu_map_pkg::AREA_INT) begin
                    if (!writeReg && vecRead) begin
                        rdataNext = emu_map_pkg::INDEF_DATA;
                    end else if (fetchReg && breakRd) begin
                        rdataNext = {memRd[15:8], emu_map_pkg::BREAK_OPCODE};
                    end else begin
                        rdataNext = memRd;
                    end
                    stateNext = emu_map_pkg::ST_DONE;
                end else begin
                    rdNext = writeReg;
                    wrNext = !writeReg;
                    csNext = (areaReg != emu_map_pkg::AREA_EXT);
                    oeNext = writeReg;
                    doutNext = wdataReg;
                    cntNext = emu_map_pkg::STROBE_CYCLES;
                    stateNext = emu_map_pkg::ST_STROBE;
                end
            end
            emu_map_pkg::ST_STROBE: begin
                cntNext = cntReg - 2'h1;
                if (cntReg != 2'h1) begin
                    rdNext = writeReg;
                    wrNext = !writeReg;
                    csNext = (areaReg != emu_map_pkg::AREA_EXT);
                    oeNext = writeReg;
                end else begin
                    stateNext = emu_map_pkg::ST_DONE;
                end
            end
            emu_map_pkg::ST_DONE: begin
                doneNext = 1'b1;
                // The second sync stage now holds a pin sample taken while the read strobe was low.
                if (!writeReg && areaReg != emu_map_pkg::AREA_INT) begin
                    rdataNext = dataSync2Reg;
                end
                if (!writeReg && addrReg == emu_map_pkg::INT_VEC_ADDR) begin
                    clrNext = 1'b1;
                    if (!ackReg) begin
                        alarmNext = 1'b1;
                    end
                end
                stateNext = emu_map_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stateReg <= emu_map_pkg::ST_IDLE;
            areaReg <= emu_map_pkg::AREA_INT;
            cntReg <= '0;
            addrReg <= '0;
            wdataReg <= '0;
            beReg <= '0;
            writeReg <= 1'b0;
            fetchReg <= 1'b0;
            ackReg <= 1'b0;
            cpuDone <= 1'b0;
            cpuRdata <= '0;
            intRequestClear <= 1'b0;
            alarmLed <= 1'b0;
            extAddr <= '0;
            upper_byte_enable_n <= 1'b1;
            extAle <= 1'b0;
            extRdN <= 1'b1;
            extWrN <= 1'b1;
            extCsN <= 1'b1;
            extDataOut <= '0;
            extDataOe <= 1'b0;
        end else begin
            stateReg <= stateNext;
            areaReg <= areaNext;
            cntReg <= cntNext;
            addrReg <= addrNext;
            wdataReg <= wdataNext;
            beReg <= beNext;
            writeReg <= writeNext;
            fetchReg <= fetchNext;
            ackReg <= ackNext;
            cpuDone <= doneNext;
            cpuRdata <= rdataNext;
            intRequestClear <= clrNext;
            alarmLed <= alarmNext;
            extAddr <= extAddrNext;
            upper_byte_enable_n <= ubeNext;
            extAle <= aleNext;
            extRdN <= rdNext;
            extWrN <= wrNext;
            extCsN <= csNext;
            extDataOut <= doutNext;
            extDataOe <= oeNext;
        end
    end

endmodule : emulation_map_bus_monitor

// *** dv/emulation_map_bus_monitor_checker.sv ***
module emulation_map_bus_monitor_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Watched signals
    input wire logic cpuDone,
    input wire logic intRequestClear,
    input wire logic extAle,
    input wire logic extRdN,
    input wire logic extWrN,
    input wire logic extCsN,
    input wire logic extDataOe,
    input wire logic holdReqN,
    input wire logic portsHold,
    input wire logic alarmLed
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    alarm_sticky_a: assert property (alarmLed |=> alarmLed) else $error("alarm dropped");
    alarm_cause_a: assert property ($rose(alarmLed) |-> intRequestClear && cpuDone) else $error("alarm no read");
    clear_done_a: assert property (intRequestClear |-> cpuDone) else $error("clear without done");
    ale_pulse_a: assert property (extAle |=> !extAle) else $error("ale too long");
    one_strobe_a: assert property (extRdN || extWrN) else $error("rd and wr low");
    strobe_width_a: assert property ($fell(extRdN && extWrN) |=> !(extRdN && extWrN) ##1 (extRdN && extWrN))
        else $error("strobe width");
    ale_first_a: assert property ($fell(extRdN && extWrN) |-> $past(extAle)) else $error("no ale before strobe");
    done_after_a: assert property ($rose(extRdN && extWrN) |=> cpuDone) else $error("late done");
    oe_write_a: assert property (extDataOe |-> !extWrN) else $error("oe outside write");
    float_read_a: assert property (!extRdN |-> !extDataOe) else $error("drive on read");
    hold_entry_a: assert property ($fell(holdReqN) |-> ##[4:8] portsHold) else $error("hold late");
    cover property (intRequestClear && !alarmLed);
    cover property (!extRdN && extCsN);
    cover property (!extWrN && !extCsN);
    cover property ($rose(portsHold));
endmodule : emulation_map_bus_monitor_checker

bind emulation_map_bus_monitor emulation_map_bus_monitor_checker u_chk (.*);

// *** dv/emulation_map_bus_monitor_tb_top.sv ***
module emulation_map_bus_monitor_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, resetn = 0, cpuReq = 0, cpuWrite = 0, cpuFetch = 0, cpuIntAck = 0, resetHandling = 0;
    logic mapWe = 0, mapInternal = 0, breakWe = 0, breakSet = 0, holdReqN = 1;
    logic [1:0] cpuByteEn = 2'h3;
    logic [19:0] cpuAddr = 20'h00000, extAddr;
    logic [15:0] cpuWdata = 16'h0000, cpuRdata, extDataOut, extDataIn, rd;
    logic [9:0] mapRegion = 10'h000;
    logic [10:0] breakIndex = 11'h000;
    logic cpuDone, intRequestClear, upper_byte_enable_n, extAle, extRdN, extWrN, extCsN, extDataOe, portsHold, alarmLed;
    logic sawRd, sawWr, sawCs, sawClr;
    int lat, n_fail = 0, compares = 0;
    always #20 clk_sys = ~clk_sys;
    emulation_map_bus_monitor u_dut (.*);
    target_bus_model u_model (.*);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic acc(input logic [19:0] a, input logic w, input logic [15:0] d, input logic f, input logic k);
        @(negedge clk_sys);
        {cpuAddr, cpuWrite, cpuWdata, cpuFetch, cpuIntAck, cpuReq} = {a, w, d, f, k, 1'b1};
        {sawRd, sawWr, sawCs, lat} = '0;
        while (cpuDone !== 1'b1 && lat < 20) begin
            @(negedge clk_sys);
            lat++;
            sawRd |= !extRdN;
            sawWr |= !extWrN;
            sawCs |= !extCsN;
        end
        sawClr = intRequestClear;
        rd = cpuRdata;
        cpuReq = 0;
    endtask : acc
    task automatic map(input logic [9:0] r, input logic i);
        @(negedge clk_sys);
        {mapRegion, mapInternal, mapWe} = {r, i, 1'b1};
        @(negedge clk_sys);
        mapWe = 0;
    endtask : map
    task automatic t_map;
        chk("reset pins", 16'h0007, 16'({extRdN, extWrN, extCsN}));
        acc(20'h01000, 1, 16'h5a3c, 0, 0);
        chk("int lat", 16'h0003, 16'(lat));
        chk("int addr", 16'h1000, extAddr[15:0]);
        chk("int ube", 16'h0000, 16'(upper_byte_enable_n));
        acc(20'h01000, 0, 0, 0, 0);
        chk("int rd", 16'h5a3c, rd);
        chk("int strobes", 16'h0000, 16'({sawRd, sawWr, sawCs}));
        acc(20'h00206, 0, 0, 0, 0);
        chk("periph rd", 16'h3333, rd);
        chk("periph strobes", 16'h0004, 16'({sawRd, sawWr, sawCs}));
        map(10'h005, 0);
        acc(20'h01404, 1, 16'hc0de, 0, 0);
        chk("ext wr strobes", 16'h0003, 16'({sawRd, sawWr, sawCs}));
        acc(20'h01404, 0, 0, 0, 0);
        chk("ext rd", 16'hc0de, rd);
        chk("ext lat", 16'h0005, 16'(lat));
        map(10'h005, 1);
        acc(20'h01404, 0, 0, 0, 0);
        chk("remap lat", 16'h0003, 16'(lat));
        $display("t_map done");
    endtask : t_map
    task automatic t_vec;
        logic [19:0] v [3] = '{20'hffff4, 20'hfffec, 20'hfffe4};
        foreach (v[i]) begin
            acc(v[i] + 20'h2, 1, 16'h1234, 0, 0);
            acc(v[i] + 20'h2, 0, 0, 0, 0);
            chk("vec rd", 16'hffff, rd);
        end
        $display("t_vec done");
    endtask : t_vec
    task automatic t_brk;
        acc(20'h02010, 1, 16'h1234, 0, 0);
        @(negedge clk_sys);
        {breakIndex, breakSet, breakWe} = {11'h008, 2'h3};
        @(negedge clk_sys);
        breakWe = 0;
        acc(20'h02010, 0, 0, 1, 0);
        chk("brk fetch", 16'h1200, rd);
        acc(20'h02010, 0, 0, 0, 0);
        chk("plain rd", 16'h1234, rd);
        map(10'h008, 0);
        acc(20'h02010, 0, 0, 1, 0);
        chk("ext fetch", 16'h8888, rd);
        map(10'h008, 1);
        $display("t_brk done");
    endtask : t_brk
    task automatic t_stack;
        map(10'h03f, 0);
        resetHandling = 1;
        acc(20'h0fffc, 1, 16'hbeef, 0, 0);
        acc(20'h0fffc, 0, 0, 0, 0);
        chk("stack rd", 16'hbeef, rd);
        chk("stack lat", 16'h0003, 16'(lat));
        resetHandling = 0;
        map(10'h03f, 1);
        $display("t_stack done");
    endtask : t_stack
    task automatic t_alarm;
        acc(20'h00000, 0, 0, 0, 1);
        chk("ack clr", 16'h0001, 16'(sawClr));
        chk("ack alarm", 16'h0000, 16'(alarmLed));
        acc(20'h00000, 0, 0, 0, 0);
        chk("stray clr", 16'h0001, 16'(sawClr));
        chk("alarm on", 16'h0001, 16'(alarmLed));
        acc(20'h01000, 0, 0, 0, 0);
        chk("alarm held", 16'h0001, 16'(alarmLed));
        @(negedge clk_sys);
        resetn = 0;
        @(negedge clk_sys);
        resetn = 1;
        chk("alarm off", 16'h0000, 16'(alarmLed));
        $display("t_alarm done");
    endtask : t_alarm
    task automatic t_hold;
        @(negedge clk_sys);
        {holdReqN, lat} = '0;
        while (portsHold !== 1'b1 && lat < 20) begin
            @(negedge clk_sys);
            lat++;
        end
        chk("hold lat", 16'h0001, 16'(lat >= 5 && lat <= 7));
        holdReqN = 1;
        repeat (4) @(negedge clk_sys);
        chk("hold off", 16'h0000, 16'(portsHold));
        $display("t_hold done");
    endtask : t_hold
    task automatic test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    initial begin
        #100000;
        n_fail++;
        test_done();
    end
    initial begin
        repeat (3) @(negedge clk_sys);
        resetn = 1;
        t_map();
        t_vec();
        t_brk();
        t_stack();
        t_alarm();
        t_hold();
        test_done();
    end
endmodule : emulation_map_bus_monitor_tb_top

// *** dv/target_bus_model.sv ***
module target_bus_model (
    // Target bus pins
    input wire logic clk_sys,
    input wire logic [19:0] extAddr,
    input wire logic extRdN,
    input wire logic extWrN,
    input wire logic [15:0] extDataOut,
    input wire logic extDataOe,
    output logic [15:0] extDataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    initial for (int i = 0; i < 16; i++) mem[i] = {4{4'(i)}};
    // target read answer, released bus shows the inverse.
    assign extDataIn = !extRdN ? mem[extAddr[4:1]] : ~last;
    always @(posedge clk_sys) begin
        if (!extWrN && extDataOe) mem[extAddr[4:1]] <= extDataOut;
        if (!extRdN) last <= extDataIn;
    end
endmodule : target_bus_model
